//--- logic/host_port_map.vh
// constants for the parallel host register port
`ifndef HOST_PORT_MAP_VH
`define HOST_PORT_MAP_VH
`define HP_DATA_W        8
`define HP_ADDR_W        8
`define HP_TEST_BIT      7
`define HP_NORM_DEPTH    128
`define HP_TEST_DEPTH    128
`define HP_REG_RESET     8'h00
`define HP_STRAP_STROBE_DIR 1'b0
`endif

//--- logic/host_register_bus_interface.v
// parallel host register port with strap-selected bus style
// Operation
// RULE_01 - strap low: strobe plus direction mode
// RULE_02 - strap high: separate read and write strobes
// RULE_03 - host holds chip select low per access
// RULE_04 - host pulls read enable low to read
// RULE_05 - drive data while read and select low
// RULE_06 - host pulls write strobe low to write
// RULE_07 - write captured on write strobe rising edge
// RULE_08 - host holds access strobe high per access
// RULE_09 - direction high reads: drive addressed data
// RULE_10 - write captured on access strobe falling edge
// RULE_11 - one bidirectional eight-bit data bus
// RULE_12 - address bus selects the register
// RULE_13 - address latch transparent while enable high
// RULE_14 - top address bit selects test space
// RULE_15 - data drivers released outside read conditions
`default_nettype none
`include "host_port_map.vh"
module host_register_bus_interface #(
  parameter DATA_W     = `HP_DATA_W,
  parameter ADDR_W     = `HP_ADDR_W,
  parameter NORM_DEPTH = `HP_NORM_DEPTH,
  parameter TEST_DEPTH = `HP_TEST_DEPTH
) (
  input  wire              clock_in,
  input  wire              rst_b_in,
  input  wire              bus_style_strap_n_in,
  input  wire              chip_select_n_in,
  input  wire              read_enable_n_in,
  input  wire              write_strobe_n_in,
  input  wire              addr_latch_enable_in,
  input  wire [ADDR_W-1:0] address_in,
  input  wire [DATA_W-1:0] data_in,
  output reg  [DATA_W-1:0] data_out,
  output reg               data_oe_n_out,
  output wire              separate_strobe_mode_out,
  output wire [DATA_W-1:0] control_reg0_out
);
  localparam IDX_W = ADDR_W - 1;

  // reset release through two flops
  reg rst_meta_q;
  reg rst_q;
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_q <= 1'b0;
      rst_q      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q      <= rst_meta_q;
    end
  end

  // all asynchronous pins pass through a synchroniser; the host strobes
  // must therefore be several clock periods wide
  wire [3:0] ctl_sync;
  pin_sync #(
    .W (4)
  ) u_ctl_sync (
    .clock_in (clock_in),
    .rst_b    (rst_q),
    .async_in ({bus_style_strap_n_in, chip_select_n_in,
                read_enable_n_in, write_strobe_n_in}),
    .sync_out (ctl_sync)
  );
  wire strap_s = ctl_sync[3];
  wire cs_n_s  = ctl_sync[2];
  wire rd_s    = ctl_sync[1];
  wire wr_s    = ctl_sync[0];

  // start-up sequence: the synchronisers refill from the pins before the
  // strap is caught and before any strobe edge is decoded, so their reset
  // values can never pass for an access or for the bus style
  localparam [1:0] ST_FILL  = 2'b00;
  localparam [1:0] ST_PRIME = 2'b01;
  localparam [1:0] ST_STRAP = 2'b10;
  localparam [1:0] ST_RUN   = 2'b11;
  reg [1:0] start_q;
  reg [1:0] start_d;
  always @* begin
    start_d = start_q;
    case (start_q)
      ST_FILL:  start_d = ST_PRIME;
      ST_PRIME: start_d = ST_STRAP;
      ST_STRAP: start_d = ST_RUN;
      ST_RUN:   start_d = ST_RUN;
      default:  start_d = ST_FILL;
    endcase
  end
  always @(posedge clock_in or negedge rst_q) begin
    if (!rst_q) begin
      start_q <= ST_FILL;
    end else begin
      start_q <= start_d;
    end
  end
  wire decode_on = (start_q == ST_RUN);

  // strap caught once the synchroniser holds the pin, fixed thereafter;
  // a strap change needs a fresh reset
  reg strap_q;
  always @(posedge clock_in or negedge rst_q) begin
    if (!rst_q) begin
      strap_q <= 1'b1;
    end else if (start_q == ST_STRAP) begin
      strap_q <= strap_s; // RULE_01 RULE_02
    end
  end
  wire sep_mode = (strap_q != `HP_STRAP_STROBE_DIR); // RULE_01 RULE_02
  assign separate_strobe_mode_out = sep_mode;

  // address latch; with the latch enable high it follows the pins
  reg [ADDR_W-1:0] addr_hold_q;
  reg [ADDR_W-1:0] addr_s1_q;
  reg [ADDR_W-1:0] addr_s2_q;
  reg [DATA_W-1:0] wdata_s1_q;
  reg [DATA_W-1:0] wdata_s2_q;
  reg              ale_s1_q;
  reg              ale_s2_q;
  always @(posedge clock_in or negedge rst_q) begin
    if (!rst_q) begin
      addr_s1_q   <= {ADDR_W{1'b0}};
      addr_s2_q   <= {ADDR_W{1'b0}};
      addr_hold_q <= {ADDR_W{1'b0}};
      wdata_s1_q  <= {DATA_W{1'b0}};
      wdata_s2_q  <= {DATA_W{1'b0}};
      ale_s1_q    <= 1'b1;
      ale_s2_q    <= 1'b1;
    end else begin
      addr_s1_q  <= address_in;
      addr_s2_q  <= addr_s1_q;
      wdata_s1_q <= data_in;
      wdata_s2_q <= wdata_s1_q;
      ale_s1_q   <= addr_latch_enable_in;
      ale_s2_q   <= ale_s1_q;
      if (ale_s2_q)
        addr_hold_q <= addr_s2_q; // RULE_13
    end
  end
  wire [ADDR_W-1:0] addr_eff = ale_s2_q ? addr_s2_q : addr_hold_q; // RULE_13
  wire              test_sel = addr_eff[`HP_TEST_BIT]; // RULE_14
  wire [IDX_W-1:0]  reg_idx  = addr_eff[IDX_W-1:0]; // RULE_12

  // access decode per bus style
  reg rd_prev_q;
  reg wr_prev_q;
  always @(posedge clock_in or negedge rst_q) begin
    if (!rst_q) begin
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
    end else begin
      rd_prev_q <= rd_s;
      wr_prev_q <= wr_s;
    end
  end
  wire read_act_sep  = !rd_s && !cs_n_s; // RULE_05
  wire read_act_dir  = rd_s && wr_s && !cs_n_s; // RULE_09
  wire write_sep     = !wr_prev_q && wr_s && !cs_n_s; // RULE_07
  wire write_dir     = rd_prev_q && !rd_s && !cs_n_s && !wr_s; // RULE_10
  // nothing is decoded until the start-up sequence is done
  reg read_act;
  reg write_evt;
  always @* begin
    read_act  = 1'b0;
    write_evt = 1'b0;
    case ({decode_on, sep_mode})
      2'b11: begin
        read_act  = read_act_sep;
        write_evt = write_sep;
      end
      2'b10: begin
        read_act  = read_act_dir;
        write_evt = write_dir;
      end
      default: begin
        read_act  = 1'b0;
        write_evt = 1'b0;
      end
    endcase
  end

  // normal and test register spaces in flip-flops
  reg [DATA_W-1:0] norm_mem [0:NORM_DEPTH-1];
  reg [DATA_W-1:0] test_mem [0:TEST_DEPTH-1];
  wire             norm_we = write_evt && !test_sel; // RULE_14
  wire             test_we = write_evt && test_sel; // RULE_14
  integer i;
  integer j;
  always @(posedge clock_in or negedge rst_q) begin
    if (!rst_q) begin
      for (i = 0; i < NORM_DEPTH; i = i + 1)
        norm_mem[i] <= `HP_REG_RESET;
    end else if (norm_we) begin
      norm_mem[reg_idx] <= wdata_s2_q; // RULE_11
    end
  end
  always @(posedge clock_in or negedge rst_q) begin
    if (!rst_q) begin
      for (j = 0; j < TEST_DEPTH; j = j + 1)
        test_mem[j] <= `HP_REG_RESET;
    end else if (test_we) begin
      test_mem[reg_idx] <= wdata_s2_q; // RULE_11
    end
  end

  // the addressed word is re-read every cycle of a read, so a write that
  // lands during a read shows at once; data stays put once the read ends
  wire [DATA_W-1:0] rd_word;
  assign rd_word = test_sel ? test_mem[reg_idx] : norm_mem[reg_idx]; // RULE_14
  assign control_reg0_out = norm_mem[0];

  // read data and drivers registered; enable low while driving
  always @(posedge clock_in or negedge rst_q) begin
    if (!rst_q) begin
      data_out      <= {DATA_W{1'b0}};
      data_oe_n_out <= 1'b1;
    end else begin
      data_oe_n_out <= !read_act; // RULE_15
      if (read_act)
        data_out <= rd_word; // RULE_11
    end
  end
endmodule // host_register_bus_interface
`default_nettype wire

//--- logic/pin_sync.v
// two-flop synchroniser for a group of level inputs
`default_nettype none
module pin_sync #(
  parameter W = 1
) (
  input  wire         clock_in,
  input  wire         rst_b,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // pin_sync
`default_nettype wire

//--- sim/host_cpu_model.sv
// host processor model for the parallel register port
`default_nettype none
module host_cpu_model (
  input  wire logic       clock_in,
  input  wire logic       sep_in,
  input  wire logic [7:0] dout_in,
  input  wire logic       oe_n_in,
  output var  logic       cs_n_out = 1,
  output var  logic       rd_out = 1,
  output var  logic       wr_out = 1,
  output var  logic       ale_out = 1,
  output var  logic [7:0] addr_out = 0,
  output wire logic [7:0] bus_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hd = 0;
  logic       hdrv = 0;
  // a released bus must not look like the last value driven
  assign bus_out = !oe_n_in ? dout_in : hdrv ? hd : ~hd;
  task acc(input logic w, sel, input logic [7:0] a, d,
           output logic [7:0] q);
    @(posedge clock_in);
    rd_out <= sep_in;
    wr_out <= !w;
    addr_out <= a;
    ale_out <= 1;
    hd <= d;
    hdrv <= w;
    @(posedge clock_in);
    cs_n_out <= !sel;
    rd_out <= sep_in ? w : 1'b1;
    repeat (5) @(posedge clock_in);
    ale_out <= 0;
    addr_out <= ~a;
    repeat (5) @(posedge clock_in);
    q = bus_out;
    rd_out <= sep_in;
    if (sep_in) wr_out <= 1;
    repeat (5) @(posedge clock_in);
    cs_n_out <= 1;
    wr_out <= 1;
    hdrv <= 0;
    repeat (4) @(posedge clock_in);
  endtask
endmodule // host_cpu_model
`default_nettype wire

//--- sim/host_register_bus_interface_tb.sv
// self-checking bench for the host register port
`default_nettype none
module host_register_bus_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock_in = 0;
  logic       rst_b_in = 0;
  logic       strap = 1;
  logic       cs_n, rd, wr, ale, oe_n, sm;
  logic [7:0] addr, bus, dout, reg0, q;
  logic [7:0] mem [256];
  logic [7:0] as [24];
  int         error_cnt = 0;
  int         n_tests = 0;
  host_register_bus_interface u_dut (.clock_in(clock_in),
    .rst_b_in(rst_b_in), .bus_style_strap_n_in(strap),
    .chip_select_n_in(cs_n), .read_enable_n_in(rd),
    .write_strobe_n_in(wr), .addr_latch_enable_in(ale),
    .address_in(addr), .data_in(bus), .data_out(dout),
    .data_oe_n_out(oe_n), .separate_strobe_mode_out(sm),
    .control_reg0_out(reg0));
  host_cpu_model h (.clock_in(clock_in), .sep_in(strap), .dout_in(dout),
    .oe_n_in(oe_n), .cs_n_out(cs_n), .rd_out(rd), .wr_out(wr),
    .ale_out(ale), .addr_out(addr), .bus_out(bus));
  task check(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t saw %h want %h", $time, got, exp);
    end
  endtask
  task final_report;
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function logic [7:0] expect_of(input logic [7:0] a);
    return mem[a];
  endfunction
  initial forever #2.5 clock_in = ~clock_in;
  // about 102 accesses of 21 cycles each, with a wide margin
  initial begin
    #100000;
    error_cnt++;
    final_report;
  end
  initial begin
    void'($urandom(32'h3B25B072));
    for (int s = 1; s >= 0; s--) begin
      @(posedge clock_in);
      rst_b_in <= 0;
      strap <= s[0];
      repeat (4) @(posedge clock_in);
      rst_b_in <= 1;
      repeat (8) @(posedge clock_in);
      foreach (mem[i]) mem[i] = 8'h00;
      check(sm, s[0]);
      h.acc(0, 1, 8'h00, 8'h00, q);
      check(q, 8'h00);
      for (int i = 0; i < 24; i++) begin
        as[i] = i < 2 ? {i[0], 7'h00} : 8'($urandom);
        mem[as[i]] = 8'($urandom);
        h.acc(1, 1, as[i], mem[as[i]], q);
      end
      check(reg0, expect_of(8'h00));
      foreach (as[i]) begin
        h.acc(0, 1, as[i], 8'h00, q);
        check(q, expect_of(as[i]));
      end
      // strobes with chip select high must neither write nor drive
      h.acc(1, 0, 8'h00, ~mem[8'h00], q);
      check(reg0, expect_of(8'h00));
      h.acc(0, 0, 8'h00, mem[8'h00], q);
      check(q, ~mem[8'h00]);
    end
    final_report;
  end
endmodule // host_register_bus_interface_tb
`default_nettype wire

//--- sim/hrbi_monitor.sv
// pin-level checks for the host register port
`default_nettype none
module hrbi_monitor (
  input wire logic       clock_in,
  input wire logic       rst_b_in,
  input wire logic       bus_style_strap_n_in,
  input wire logic       chip_select_n_in,
  input wire logic       read_enable_n_in,
  input wire logic       write_strobe_n_in,
  input wire logic       addr_latch_enable_in,
  input wire logic [7:0] address_in,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_n_out,
  input wire logic       separate_strobe_mode_out,
  input wire logic [7:0] control_reg0_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  wire logic sm = separate_strobe_mode_out;
  wire logic rd = read_enable_n_in;
  wire logic wr = write_strobe_n_in;
  wire logic rd_c = !chip_select_n_in && (sm ? !rd : rd && wr);
  // host-side view of the address latch, so a write is judged by the
  // address it was latched with, not by what the pins show later
  logic [7:0] alat_q = 8'h00;
  always @(posedge clock_in)
    if (addr_latch_enable_in)
      alat_q <= address_in;
  wire logic [7:0] aeff = addr_latch_enable_in ? address_in : alat_q;
  wire logic w0 = !chip_select_n_in && aeff == 8'h00;
  rd_drive_a: assert property (rd_c [*5] |-> !data_oe_n_out)
    else $error("read not driven");
  bus_free_a: assert property (!rd_c [*6] |-> data_oe_n_out)
    else $error("bus held");
  mode_pick_a: assert property (rst_b_in [*8] |->
    sm == bus_style_strap_n_in) else $error("bad mode");
  sep_write_a: assert property (sm && w0 && $rose(wr) |->
    ##[2:5] control_reg0_out == data_in) else $error("no sep write");
  dir_write_a: assert property (!sm && w0 && !wr && $fell(rd) |->
    ##[2:5] control_reg0_out == data_in) else $error("no dir write");
  no_select_a: assert property (chip_select_n_in [*8] |->
    $stable(control_reg0_out)) else $error("write unselected");
  drive_cause_a: assert property ($fell(data_oe_n_out) |->
    $past(rd_c, 3)) else $error("spurious drive");
  read_steady_a: assert property (!data_oe_n_out [*2] |->
    $stable(data_out)) else $error("read data moved");
  cover property (rd_c [*5] && sm);
  cover property (rd_c [*5] && !sm);
  cover property (w0 && $rose(wr));
  cover property (w0 && !sm && !wr && $fell(rd));
endmodule // hrbi_monitor
bind host_register_bus_interface hrbi_monitor u_mon (.*);
`default_nettype wire
